// *** core/grl_cmd_decode.sv ***
// Purpose: Decode accepted bus bytes into command strobes
// Assumes: byte_data stable while byte_stb is high
// Notes: Strobes follow byte_stb by one cycle
`include "grl_consts.svh"
module grl_cmd_decode (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Command path
  grl_cmd_if.dec   cif
);
  import grl_pkg::*;

  logic [6:0] c;
  logic       cmd;

  assign c   = cif.byte_data[6:0];
  assign cmd = cif.byte_stb && cif.byte_atn;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cif.mla <= 1'b0;
      cif.mta <= 1'b0;
      cif.unl <= 1'b0;
      cif.unt <= 1'b0;
      cif.gtl <= 1'b0;
      cif.llo <= 1'b0;
      cif.dcl <= 1'b0;
      cif.sdc <= 1'b0;
      cif.get <= 1'b0;
      cif.dab <= 1'b0;
    end
    else if (clk_en)
    begin
      cif.mla <= cmd && c == {`GRL_LISTEN_GRP, cif.my_addr};
      cif.mta <= cmd && c == {`GRL_TALK_GRP, cif.my_addr};
      cif.unl <= cmd && c == `GRL_CMD_UNL;
      cif.unt <= cmd && c == `GRL_CMD_UNT;
      cif.gtl <= cmd && c == `GRL_CMD_GTL;
      cif.llo <= cmd && c == `GRL_CMD_LLO;
      cif.dcl <= cmd && c == `GRL_CMD_DCL;
      cif.sdc <= cmd && c == `GRL_CMD_SDC;
      cif.get <= cmd && c == `GRL_CMD_GET;
      cif.dab <= cif.byte_stb && !cif.byte_atn;
    end
endmodule

// *** core/grl_core.sv ***
// Purpose: Instrument-side bus remote/local, address and error logic
// Assumes: Bus pins asynchronous; panel and engine signals on pclk
// Notes: APB answers in the first access cycle
//
// Behaviour
// - Option checks wait for the execute character before flagging
// - Out-of-range, conflict or unfitted module also flag illegal option
// - Each illegal-option error sets a bit in the error status word
// - Trigger while a reading is running reports overrun
// - Overrun trigger neither aborts nor restarts the running reading
// - Calibration other than drift correction is rejected when locked
// - Own talk address makes talker; UNT, listen address, IFC idle it
// - Own listen address makes listener; UNL, talk address, IFC idle it
// - Remote entered only when addressed to listen with REN true
// - In remote every panel key except local is ignored
// - Leaving remote re-enables panel keys unless lockout holds
// - Local key cancels remote and clears the user display message
// - Under local lockout the local key does nothing
// - Talk addressing works in remote and in local mode
// - Panel editing or buffer viewing stalls bus data bytes; command bytes still pass
// - Go-to-local leaves remote; keys stay locked under lockout
// - Only REN false clears lockout; it also clears remote
// - Device clear restores default operating conditions
//
// Our own choices: the APB interface to the registers and the register offsets.
`include "grl_consts.svh"
module grl_core (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Bus pins, active low
  input  wire logic             atn_n,
  input  wire logic             ren_n,
  input  wire logic             ifc_n,
  input  wire logic             dav_n,
  input  wire grl_pkg::grl_byte_t dio_n,
  output logic                  nrfd_o,
  output logic                  nrfd_oe,
  output logic                  ndac_o,
  output logic                  ndac_oe,
  // Instrument side
  input  wire logic             cal_lock,
  input  wire logic             meas_busy,
  input  wire logic             ext_trig,
  input  wire logic             mode_conflict,
  input  wire logic [1:0]       module_fitted,
  input  wire logic             panel_busy,
  input  wire logic             key_stb,
  input  wire logic [4:0]       key_code,
  output logic                  key_out_stb,
  output logic      [4:0]       key_out_code,
  output logic                  meas_start,
  output logic                  cal_start,
  output grl_pkg::grl_byte_t    cal_opt,
  output logic                  dev_clear,
  output logic                  msg_show,
  output logic                  talk_ind,
  output logic                  listen_ind,
  output logic                  remote_ind,
  output logic                  llo_ind
);
  import grl_pkg::*;

  function automatic logic [1:0] grl_check(grl_byte_t l, grl_byte_t o,
                                           logic [1:0] fit);
    grl_byte_t lim;
    lim = 8'h00;
    grl_check = 2'b00;
    case (l)
      `GRL_CH_TRIG: lim = `GRL_LIM_TRIG;
      `GRL_CH_CAL:  lim = `GRL_LIM_CAL;
      `GRL_CH_FREQ: lim = `GRL_LIM_FREQ;
      `GRL_CH_K:    lim = `GRL_LIM_K;
      `GRL_CH_DISP: lim = `GRL_LIM_DISP;
      default:      grl_check = 2'b10;
    endcase
    if (!grl_check[1] && (o > lim || (l == `GRL_CH_FREQ && !fit[o[0]])))
      grl_check = 2'b01;
  endfunction

  function automatic logic [1:0] grl_sel(logic [11:0] a);
    case (a)
      `GRL_OFS_CTRL:              grl_sel = 2'b01;
      `GRL_OFS_STATUS:            grl_sel = 2'b10;
      `GRL_OFS_ERROR_STATUS_WORD: grl_sel = 2'b11;
      default:                    grl_sel = 2'b00;
    endcase
  endfunction

  // Pin synchronisers
  logic [12:0] s1_r;
  logic [12:0] s2_r;
  logic        atn;
  logic        ren;
  logic        ifc;
  logic        dav;
  logic        lock;
  grl_byte_t   dio;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      s1_r <= 13'h0FFF;
      s2_r <= 13'h0FFF;
    end
    else if (clk_en)
    begin
      s1_r <= {cal_lock, dav_n, ifc_n, ren_n, atn_n, dio_n};
      s2_r <= s1_r;
    end

  assign dio  = ~s2_r[7:0];
  assign atn  = !s2_r[8];
  assign ren  = !s2_r[9];
  assign ifc  = !s2_r[10];
  assign dav  = !s2_r[11];
  assign lock = s2_r[12];
  assign nrfd_o = 1'b0;
  assign ndac_o = 1'b0;

  // Byte acceptance handshake
  grl_ah_t   ah_r;
  logic      byte_stb_r;
  logic      byte_atn_r;
  grl_byte_t byte_r;
  logic [4:0] addr_r;
  grl_cmd_if cif ();

  assign cif.byte_stb  = byte_stb_r;
  assign cif.byte_data = byte_r;
  assign cif.byte_atn  = byte_atn_r;
  assign cif.my_addr   = addr_r;

  grl_cmd_decode u_dec (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .cif     (cif)
  );

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ah_r       <= GRL_AH_IDLE;
      byte_stb_r <= 1'b0;
      byte_atn_r <= 1'b0;
      byte_r     <= 8'h00;
      nrfd_oe    <= 1'b0;
      ndac_oe    <= 1'b0;
    end
    else if (clk_en)
    begin
      byte_stb_r <= 1'b0;
      if (ifc)
      begin
        ah_r    <= GRL_AH_IDLE;
        nrfd_oe <= 1'b0;
        ndac_oe <= 1'b0;
      end
      else
        case (ah_r)
          GRL_AH_IDLE:
          begin
            ndac_oe <= atn || listen_ind;
            if (dav && (atn || listen_ind))
            begin
              byte_r     <= dio;
              byte_atn_r <= atn;
              byte_stb_r <= 1'b1;
              nrfd_oe    <= 1'b1;
              ah_r       <= GRL_AH_HOLD;
            end
          end
          GRL_AH_HOLD:
            if (byte_atn_r || !panel_busy)
            begin
              ndac_oe <= 1'b0;
              ah_r    <= GRL_AH_DONE;
            end
          GRL_AH_DONE:
            if (!dav)
            begin
              ndac_oe <= 1'b1;
              nrfd_oe <= 1'b0;
              ah_r    <= GRL_AH_IDLE;
            end
          default: ah_r <= GRL_AH_IDLE;
        endcase
    end

  // Talker and listener address states
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      talk_ind   <= 1'b0;
      listen_ind <= 1'b0;
    end
    else if (clk_en)
    begin
      if (ifc)
      begin
        talk_ind   <= 1'b0;
        listen_ind <= 1'b0;
      end
      else if (cif.mta)
      begin
        talk_ind   <= 1'b1;
        listen_ind <= 1'b0;
      end
      else if (cif.mla)
      begin
        listen_ind <= 1'b1;
        talk_ind   <= 1'b0;
      end
      else
      begin
        if (cif.unt)
          talk_ind <= 1'b0;
        if (cif.unl)
          listen_ind <= 1'b0;
      end
    end

  // Remote, lockout and panel keys
  logic keys_lock_r;
  logic local_go;

  assign local_go = key_stb && key_code == `GRL_KEY_LOCAL && remote_ind
                    && !llo_ind;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      remote_ind  <= 1'b0;
      llo_ind     <= 1'b0;
      keys_lock_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!ren)
      begin
        remote_ind  <= 1'b0;
        llo_ind     <= 1'b0;
        keys_lock_r <= 1'b0;
      end
      else
      begin
        if (cif.llo)
          llo_ind <= 1'b1;
        if (cif.mla)
        begin
          remote_ind  <= 1'b1;
          keys_lock_r <= 1'b1;
        end
        else if (cif.gtl && listen_ind)
        begin
          remote_ind  <= 1'b0;
          keys_lock_r <= llo_ind || cif.llo;
        end
        else if (local_go)
        begin
          remote_ind  <= 1'b0;
          keys_lock_r <= 1'b0;
        end
      end
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      key_out_stb  <= 1'b0;
      key_out_code <= 5'h00;
    end
    else if (clk_en)
    begin
      key_out_stb  <= key_stb && !keys_lock_r;
      key_out_code <= key_code;
    end

  // Command string parser
  grl_byte_t let_r;
  grl_byte_t opt_r;
  grl_byte_t p_cal_r;
  logic      has_let_r;
  logic      comma_r;
  logic      go_r;
  logic      p_trig_v_r;
  logic      p_cal_v_r;
  logic      p_msg_v_r;
  logic      p_msg_r;
  logic [1:0] p_trig_r;
  logic [1:0] pend_err_r;
  logic [1:0] chk_now;
  logic      set_cmd_r;
  logic      set_opt_r;
  logic      set_cal_r;
  logic      exec_trig_r;
  logic      is_x;
  logic      is_let;
  logic      is_dig;
  logic      commit;
  logic      clean;
  logic      dev_clr_go;
  logic      bad_cal;

  assign dev_clr_go = cif.dcl || (cif.sdc && listen_ind);
  assign is_x   = cif.dab && remote_ind && byte_r == `GRL_CH_EXEC;
  assign is_let = cif.dab && remote_ind && !is_x && byte_r >= `GRL_CH_A
                  && byte_r <= `GRL_CH_Z;
  assign is_dig = cif.dab && remote_ind && byte_r >= `GRL_CH_0
                  && byte_r <= `GRL_CH_9;
  assign commit = has_let_r && (is_let || is_x);
  assign chk_now = grl_check(let_r, opt_r, module_fitted);
  assign clean  = pend_err_r == 2'b00 && !mode_conflict;
  assign bad_cal = p_cal_v_r && lock && p_cal_r != 8'h00;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      let_r       <= 8'h00;
      opt_r       <= 8'h00;
      p_cal_r     <= 8'h00;
      has_let_r   <= 1'b0;
      comma_r     <= 1'b0;
      go_r        <= 1'b0;
      p_trig_v_r  <= 1'b0;
      p_cal_v_r   <= 1'b0;
      p_msg_v_r   <= 1'b0;
      p_msg_r     <= 1'b0;
      p_trig_r    <= 2'h0;
      pend_err_r  <= 2'h0;
      set_cmd_r   <= 1'b0;
      set_opt_r   <= 1'b0;
      set_cal_r   <= 1'b0;
      exec_trig_r <= 1'b0;
      cal_start   <= 1'b0;
      cal_opt     <= 8'h00;
      msg_show    <= 1'b0;
    end
    else if (clk_en)
    begin
      go_r        <= is_x && !dev_clr_go;
      set_cmd_r   <= go_r && pend_err_r[1];
      set_opt_r   <= go_r && (pend_err_r[0] || mode_conflict);
      set_cal_r   <= go_r && clean && bad_cal;
      exec_trig_r <= go_r && clean && p_trig_v_r;
      cal_start   <= go_r && clean && p_cal_v_r && !bad_cal;
      if (go_r)
        cal_opt <= p_cal_r;
      if (dev_clr_go || local_go)
        msg_show <= 1'b0;
      else if (go_r && clean && p_msg_v_r)
        msg_show <= p_msg_r;
      if (dev_clr_go || go_r)
      begin
        has_let_r  <= 1'b0;
        pend_err_r <= 2'h0;
        p_trig_v_r <= 1'b0;
        p_cal_v_r  <= 1'b0;
        p_msg_v_r  <= 1'b0;
      end
      else
      begin
        if (commit)
        begin
          pend_err_r <= pend_err_r | chk_now;
          if (chk_now == 2'b00)
            case (let_r)
              `GRL_CH_TRIG:
              begin
                p_trig_v_r <= 1'b1;
                p_trig_r   <= opt_r[1:0];
              end
              `GRL_CH_CAL:
              begin
                p_cal_v_r <= 1'b1;
                p_cal_r   <= opt_r;
              end
              `GRL_CH_DISP:
              begin
                p_msg_v_r <= 1'b1;
                p_msg_r   <= opt_r[0];
              end
              default: p_msg_v_r <= p_msg_v_r;
            endcase
        end
        if (is_let)
        begin
          let_r     <= byte_r;
          opt_r     <= 8'h00;
          has_let_r <= 1'b1;
          comma_r   <= 1'b0;
        end
        else if (is_dig && !comma_r)
          opt_r <= (opt_r > 8'h18) ? 8'hFF
                 : 8'(opt_r * 10 + (byte_r - `GRL_CH_0));
        else if (cif.dab && byte_r == `GRL_CH_COMMA)
          comma_r <= 1'b1;
      end
    end

  // Triggering and device clear
  grl_trig_t trig_src_r;
  logic      stim;
  logic      set_ovr_r;

  assign stim = (cif.get && listen_ind && trig_src_r == GRL_TRIG_GET)
              || (ext_trig && trig_src_r == GRL_TRIG_EXT)
              || (cif.mta && trig_src_r == GRL_TRIG_TALK)
              || (go_r && clean && trig_src_r == GRL_TRIG_CMD);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      meas_start <= 1'b0;
      set_ovr_r  <= 1'b0;
      dev_clear  <= 1'b0;
    end
    else if (clk_en)
    begin
      meas_start <= stim && !meas_busy;
      set_ovr_r  <= stim && meas_busy;
      dev_clear  <= dev_clr_go;
    end

  // APB register file
  logic [1:0]  sel;
  logic [31:0] rd;
  logic [3:0]  err_r;
  logic        apb_wr;

  assign sel    = grl_sel(paddr);
  assign apb_wr = psel && penable && pready && pwrite;

  always_comb
  begin
    rd = 32'h0000_0000;
    case (sel)
      2'b01:
      begin
        rd[`GRL_CTRL_TRIG_LSB +: 2] = trig_src_r;
        rd[`GRL_CTRL_ADDR_LSB +: 5] = addr_r;
      end
      2'b10:
      begin
        rd[`GRL_ST_TALK]   = talk_ind;
        rd[`GRL_ST_LISTEN] = listen_ind;
        rd[`GRL_ST_REMOTE] = remote_ind;
        rd[`GRL_ST_LLO]    = llo_ind;
        rd[`GRL_ST_REN]    = ren;
      end
      2'b11: rd[3:0] = err_r;
      default: rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && sel == 2'b00;
      if (psel && !penable)
        prdata <= rd;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      trig_src_r <= grl_trig_t'(`GRL_RST_TRIG);
      addr_r     <= `GRL_RST_ADDR;
    end
    else if (clk_en)
    begin
      if (dev_clr_go)
        trig_src_r <= grl_trig_t'(`GRL_RST_TRIG);
      else if (exec_trig_r)
        trig_src_r <= grl_trig_t'(p_trig_r);
      else if (apb_wr && sel == 2'b01)
        trig_src_r <= grl_trig_t'(pwdata[`GRL_CTRL_TRIG_LSB +: 2]);
      if (apb_wr && sel == 2'b01)
        addr_r <= pwdata[`GRL_CTRL_ADDR_LSB +: 5];
    end

  // Sticky errors: hardware set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      err_r <= 4'h0;
    else if (clk_en)
      err_r <= (err_r & ~((apb_wr && sel == 2'b11) ? pwdata[3:0] : 4'h0))
             | {set_cal_r, set_ovr_r, set_opt_r, set_cmd_r};

  a_talk_ifc:
    assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
      ifc |=> !talk_ind && !listen_ind) else $error("talker after IFC");
  a_listen_mta:
    assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
      cif.mta && !ifc |=> !listen_ind) else $error("listener on talk");
  a_remote_cause:
    assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
      $rose(remote_ind) |-> $past(cif.mla && ren))
      else $error("remote without MLA and REN");
  a_key_block:
    assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
      key_stb && keys_lock_r |=> !key_out_stb) else $error("key passed");
  a_lockout_hold:
    assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
      key_stb && llo_ind && remote_ind && ren && !cif.gtl |=> remote_ind)
      else $error("local key worked under lockout");
  a_ren_drop:
    assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
      !ren |=> !remote_ind && !llo_ind) else $error("REN false kept state");
  a_ovr_nostart:
    assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
      stim && meas_busy |=> set_ovr_r && !meas_start)
      else $error("overrun trigger started reading");
  a_hold_bus:
    assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
      ah_r == GRL_AH_HOLD && !byte_atn_r && panel_busy && !ifc |=> ndac_oe)
      else $error("data accepted during panel hold");
  a_defer_err:
    assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
      set_opt_r |-> $past(go_r, 1)) else $error("option error before X");
  a_err_sticky:
    assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
      set_opt_r |=> err_r[`GRL_ERR_ILLEGAL_OPT]) else $error("flag lost");
  a_cal_lock:
    assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
      cal_start && cal_opt != 8'h00 |-> !$past(lock))
      else $error("locked calibration ran");
  a_get_trig:
    assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
      cif.get && !listen_ind && trig_src_r != GRL_TRIG_TALK
      && trig_src_r != GRL_TRIG_EXT && !go_r |=> !meas_start)
      else $error("unaddressed GET triggered");
endmodule

// *** pkg/grl_cmd_if.sv ***
// Purpose: Accepted bus byte to decoder and decoded strobes back
// Assumes: One clock domain
// Notes: Decoded strobes are one-cycle pulses
interface grl_cmd_if;
  import grl_pkg::*;
  logic      byte_stb;
  grl_byte_t byte_data;
  logic      byte_atn;
  logic [4:0] my_addr;
  logic      mla;
  logic      mta;
  logic      unl;
  logic      unt;
  logic      gtl;
  logic      llo;
  logic      dcl;
  logic      sdc;
  logic      get;
  logic      dab;
  modport core (output byte_stb, byte_data, byte_atn, my_addr,
                input mla, mta, unl, unt, gtl, llo, dcl, sdc, get, dab);
  modport dec (input byte_stb, byte_data, byte_atn, my_addr,
               output mla, mta, unl, unt, gtl, llo, dcl, sdc, get, dab);
endinterface

// *** pkg/grl_consts.svh ***
// Purpose: Constants for the bus remote/local state logic
// Assumes: Included by the decoder and core design modules
// Notes: Offsets are APB byte addresses
`ifndef GRL_CONSTS_SVH
`define GRL_CONSTS_SVH
// Register offsets
`define GRL_OFS_CTRL 12'h000
`define GRL_OFS_STATUS 12'h004
`define GRL_OFS_ERROR_STATUS_WORD 12'h008
// Control fields
`define GRL_CTRL_TRIG_LSB 0
`define GRL_CTRL_ADDR_LSB 8
// Status fields
`define GRL_ST_TALK 0
`define GRL_ST_LISTEN 1
`define GRL_ST_REMOTE 2
`define GRL_ST_LLO 3
`define GRL_ST_REN 4
// Error status word fields
`define GRL_ERR_ILLEGAL_CMD 0
`define GRL_ERR_ILLEGAL_OPT 1
`define GRL_ERR_OVERRUN 2
`define GRL_ERR_CAL_LOCKED 3
// Reset values
`define GRL_RST_ADDR 5'h0F
`define GRL_RST_TRIG 2'h1
// Bus command bytes
`define GRL_CMD_GTL 7'h01
`define GRL_CMD_SDC 7'h04
`define GRL_CMD_GET 7'h08
`define GRL_CMD_LLO 7'h11
`define GRL_CMD_DCL 7'h14
`define GRL_CMD_UNL 7'h3F
`define GRL_CMD_UNT 7'h5F
`define GRL_LISTEN_GRP 2'h1
`define GRL_TALK_GRP 2'h2
// Command characters
`define GRL_CH_EXEC 8'h58
`define GRL_CH_COMMA 8'h2C
`define GRL_CH_0 8'h30
`define GRL_CH_9 8'h39
`define GRL_CH_A 8'h41
`define GRL_CH_Z 8'h5A
`define GRL_CH_TRIG 8'h54
`define GRL_CH_CAL 8'h51
`define GRL_CH_FREQ 8'h46
`define GRL_CH_K 8'h4B
`define GRL_CH_DISP 8'h44
// Highest legal option per command letter
`define GRL_LIM_TRIG 8'h03
`define GRL_LIM_CAL 8'h09
`define GRL_LIM_FREQ 8'h01
`define GRL_LIM_K 8'h03
`define GRL_LIM_DISP 8'h01
// Front panel
`define GRL_KEY_LOCAL 5'h00
`endif

// *** pkg/grl_pkg.sv ***
// Purpose: Types for the bus remote/local state logic
// Assumes: Constants come from grl_consts.svh
// Notes: None
package grl_pkg;
  typedef logic [7:0] grl_byte_t;
  typedef enum logic [1:0] {GRL_TRIG_EXT, GRL_TRIG_GET, GRL_TRIG_TALK,
                            GRL_TRIG_CMD} grl_trig_t;
  typedef enum {GRL_AH_IDLE, GRL_AH_HOLD, GRL_AH_DONE} grl_ah_t;
endpackage

// *** tb/gpib_remote_local_state_logic_test.sv ***
// Purpose: Self-checking bench for the remote/local logic
// Assumes: Bus lines come from the controller model
// Notes: Strobes are counted as they pass
module gpib_remote_local_state_logic_test;
  timeunit 1ns;
  timeprecision 1ps;
  import grl_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        atn_n, ren_n, ifc_n, dav_n, nrfd_oe, ndac_oe, cal_lock;
  logic        meas_busy, panel_busy, key_stb, key_out_stb, meas_start;
  logic        dev_clear, msg_show, talk_ind, listen_ind, remote_ind;
  logic        llo_ind;
  logic        ext_trig, mode_conflict, cal_start;
  logic [1:0]  module_fitted;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  key_code;
  grl_byte_t   dio_n;
  int          n_mismatch, n_tests, n_keys, n_starts, n_clr, n_cal, cyc, k;
  grl_core dut (.pclk, .presetn, .clk_en(1'h1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .atn_n, .ren_n, .ifc_n,
    .dav_n, .dio_n, .nrfd_o(), .nrfd_oe, .ndac_o(), .ndac_oe, .cal_lock,
    .meas_busy, .ext_trig, .mode_conflict,
    .module_fitted, .panel_busy, .key_stb, .key_code, .key_out_stb,
    .key_out_code(), .meas_start, .cal_start, .cal_opt(), .dev_clear,
    .msg_show, .talk_ind, .listen_ind, .remote_ind, .llo_ind);
  grl_ctl_model ctl (.pclk, .nrfd_oe, .ndac_oe, .atn_n, .ren_n, .ifc_n,
    .dav_n, .dio_n);
  initial
  begin
    pclk = 1'h0;
    forever
      #4 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    n_keys <= n_keys + int'(key_out_stb);
    n_starts <= n_starts + int'(meas_start);
    n_clr <= n_clr + int'(dev_clear);
    n_cal <= n_cal + int'(cal_start);
    if (cyc == 20000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    check(pslverr, a > 12'h008);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic key(input logic [4:0] c);
    key_stb <= 1'h1;
    key_code <= c;
    @(posedge pclk);
    key_stb <= 1'h0;
    repeat (4)
      @(posedge pclk);
  endtask
  task automatic chars(input string s);
    foreach (s[i])
      ctl.send(1'h0, s[i]);
  endtask
  // Read the error word, compare, then clear it
  task automatic err(input logic [31:0] e);
    apb(1'h0, 12'h008, 32'h0);
    check(rd, e);
    apb(1'h1, 12'h008, 32'hF);
  endtask
  task automatic t_regs;
    apb(1'h0, 12'h000, 32'h0);
    check(rd, 32'h0000_0F01);
    apb(1'h0, 12'h00C, 32'h0);
    $display("t_regs end");
  endtask
  task automatic t_addr;
    ctl.send(1'h1, 8'h4F);
    check(talk_ind, 1'h1);
    ctl.send(1'h1, 8'h2F);
    check({talk_ind, listen_ind, remote_ind}, 3'h2);
    ctl.send(1'h1, 8'h4F);
    check({talk_ind, listen_ind}, 2'h2);
    ctl.send(1'h1, 8'h5F);
    ctl.send(1'h1, 8'h2F);
    ctl.send(1'h1, 8'h3F);
    check({talk_ind, listen_ind}, 2'h0);
    ctl.send(1'h1, 8'h4F);
    ctl.pins(1'h0, 1'h1);
    ctl.pins(1'h0, 1'h0);
    check(talk_ind, 1'h0);
    $display("t_addr end");
  endtask
  task automatic t_remote;
    ctl.remote(8'h2F);
    key(5'h03);
    check({remote_ind, n_keys[1:0]}, 3'h4);
    ctl.send(1'h1, 8'h11);
    key(5'h00);
    check({remote_ind, llo_ind}, 2'h3);
    ctl.send(1'h1, 8'h01);
    key(5'h03);
    check({remote_ind, llo_ind, n_keys[1:0]}, 4'h4);
    ctl.pins(1'h0, 1'h0);
    check({remote_ind, llo_ind}, 2'h0);
    ctl.remote(8'h2F);
    chars("D1X");
    check(msg_show, 1'h1);
    key(5'h00);
    check({remote_ind, msg_show}, 2'h0);
    k = n_keys;
    key(5'h03);
    check(n_keys, k + 1);
    $display("t_remote end");
  endtask
  task automatic t_err;
    ctl.remote(8'h2F);
    chars("K9");
    err(32'h0);
    chars("X");
    err(32'h2);
    chars("F1X");
    err(32'h2);
    module_fitted <= 2'h2;
    chars("F1X");
    err(32'h0);
    mode_conflict <= 1'h1;
    chars("K1X");
    mode_conflict <= 1'h0;
    err(32'h2);
    chars("Q1X");
    err(32'h8);
    chars("Q0X");
    err(32'h0);
    check(n_cal, 1);
    ctl.send(1'h1, 8'h08);
    check(n_starts, 1);
    meas_busy <= 1'h1;
    ctl.send(1'h1, 8'h08);
    check(n_starts, 1);
    err(32'h4);
    meas_busy <= 1'h0;
    apb(1'h1, 12'h000, 32'h0000_0F00);
    ext_trig <= 1'h1;
    @(posedge pclk);
    ext_trig <= 1'h0;
    repeat (3)
      @(posedge pclk);
    check(n_starts, 2);
    ctl.send(1'h1, 8'h14);
    ctl.send(1'h1, 8'h04);
    check(n_clr, 2);
    apb(1'h0, 12'h000, 32'h0);
    check(rd, 32'h0000_0F01);
    ctl.send(1'h1, 8'h3F);
    ctl.send(1'h1, 8'h08);
    check(n_starts, 2);
    ctl.send(1'h1, 8'h2F);
    $display("t_err end");
  endtask
  task automatic t_hold;
    panel_busy <= 1'h1;
    fork
      ctl.send(1'h0, 8'h4B);
      begin
        repeat (30)
          @(posedge pclk);
        check({nrfd_oe, ndac_oe}, 2'h3);
        panel_busy <= 1'h0;
      end
    join
    chars("0X");
    err(32'h0);
    $display("t_hold end");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, key_stb, paddr, pwdata} = '0;
    {ext_trig, mode_conflict, module_fitted} = '0;
    {key_code, cal_lock, meas_busy, panel_busy} = 8'h04;
    repeat (16)
      @(posedge pclk);
    presetn <= 1'h1;
    repeat (4)
      @(posedge pclk);
    t_regs();
    t_addr();
    t_remote();
    t_err();
    t_hold();
    tally_and_finish();
  end
endmodule

// *** tb/grl_ctl_model.sv ***
// Purpose: Bus controller model facing the remote/local logic
// Assumes: Lines are active low and float high when released
// Notes: Every handshake wait is bounded
module grl_ctl_model (
  // Clock
  input  wire logic       pclk,
  // Device handshake
  input  wire logic       nrfd_oe,
  input  wire logic       ndac_oe,
  // Controller lines
  output logic            atn_n,
  output logic            ren_n,
  output logic            ifc_n,
  output logic            dav_n,
  output logic [7:0]      dio_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {atn_n, ren_n, ifc_n, dav_n, dio_n} = 12'hFFF;
  end
  // Byte stays on the lines until the device releases NDAC
  task automatic send(input logic atn, input logic [7:0] b);
    int i;
    for (i = 0; i < 50 && nrfd_oe; i++)
      @(posedge pclk);
    @(posedge pclk);
    atn_n <= ~atn;
    dio_n <= ~b;
    @(posedge pclk);
    dav_n <= 1'h0;
    for (i = 0; i < 60 && !nrfd_oe; i++)
      @(posedge pclk);
    for (i = 0; i < 60 && ndac_oe; i++)
      @(posedge pclk);
    @(posedge pclk);
    dav_n <= 1'h1;
    dio_n <= 8'hFF;
    repeat (8)
      @(posedge pclk);
    atn_n <= 1'h1;
  endtask
  task automatic remote(input logic [7:0] la);
    ren_n <= 1'h0;
    repeat (4)
      @(posedge pclk);
    send(1'h1, la);
  endtask
  task automatic pins(input logic ren, input logic ifc);
    ren_n <= ~ren;
    ifc_n <= ~ifc;
    repeat (6)
      @(posedge pclk);
  endtask
endmodule
